//--- rtl/rtb_timebase.sv
/*
  Real-time base: prescaler, control/status register, power-state
  tracking and interrupt. Assumes the cpu gives one-cycle pulses for
  its wait and halt instructions and for other halt wake-up sources.
*/
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "rtb_map.svh"
module rtb_timebase #(
  parameter int DIV_00 = `RTB_DIV0, // ratio for code 00
  parameter int DIV_01 = `RTB_DIV1, // ratio for code 01
  parameter int DIV_10 = `RTB_DIV2, // ratio for code 10
  parameter int DIV_11 = `RTB_DIV3  // ratio for code 11
) (
  input  wire logic        SYS_CLK,       // 40 MHz clock
  input  wire logic        SRST,          // sync reset, high
  input  wire logic [7:0]  S_AXI_AWADDR,  // write address
  input  wire logic        S_AXI_AWVALID, // write address valid
  output logic             S_AXI_AWREADY, // write address ready
  input  wire logic [31:0] S_AXI_WDATA,   // write data
  input  wire logic [3:0]  S_AXI_WSTRB,   // byte enables
  input  wire logic        S_AXI_WVALID,  // write data valid
  output logic             S_AXI_WREADY,  // write data ready
  output logic [1:0]       S_AXI_BRESP,   // write response
  output logic             S_AXI_BVALID,  // write response valid
  input  wire logic        S_AXI_BREADY,  // write response ready
  input  wire logic [7:0]  S_AXI_ARADDR,  // read address
  input  wire logic        S_AXI_ARVALID, // read address valid
  output logic             S_AXI_ARREADY, // read address ready
  output logic [31:0]      S_AXI_RDATA,   // read data
  output logic [1:0]       S_AXI_RRESP,   // read response
  output logic             S_AXI_RVALID,  // read data valid
  input  wire logic        S_AXI_RREADY,  // read data ready
  input  wire logic        CPU_WAIT_REQ,  // wait instruction pulse
  input  wire logic        CPU_HALT_REQ,  // halt instruction pulse
  input  wire logic        EXT_WAKE,      // other halt wake source
  output logic [3:0]       PWR_STATE,     // one-hot power state
  output logic             TICK_IRQ,      // tick request to cpu
  output logic             IRQ            // masked event interrupt
);
  // ****************************************
  // declarations
  // ****************************************
  localparam logic [7:0] A_SIS = 8'({`RTB_IDX_SIS, 2'b00});
  localparam logic [7:0] A_TBC = 8'({`RTB_IDX_TBC, 2'b00});
  localparam logic [7:0] A_IST = 8'({`RTB_IDX_IST, 2'b00});
  localparam logic [7:0] A_IMK = 8'({`RTB_IDX_IMK, 2'b00});

  rtb_pkg::rtb_pwr_t     pwr_r;
  rtb_pkg::rtb_pwr_t     pwr_nxt;
  logic [1:0]            tb_r;
  logic                  oie_r;
  logic                  oif_r;
  logic [`RTB_EV_W-1:0]  ist_r;
  logic [`RTB_EV_W-1:0]  imk_r;
  logic [`RTB_EV_W-1:0]  ev;
  logic                  pre_en;
  logic                  tick;
  logic [`RTB_CNT_W-1:0] cnt;
  logic [1:0]            act_sel;
  logic                  frozen;
  logic                  wr;
  logic [7:0]            wr_addr;
  logic [31:0]           wr_data;
  logic [3:0]            wr_strb;
  logic                  wr_err;
  logic                  rd;
  logic [7:0]            rd_addr;
  logic [31:0]           rd_data;
  logic                  rd_err;
  logic                  tbc_wr;
  logic                  tbc_rd;
  logic                  wake_ev;

  // ****************************************
  // bus slave and prescaler
  // ****************************************
  rtb_axil u_bus (
    .clk       (SYS_CLK),
    .srst      (SRST),
    .awaddr    (S_AXI_AWADDR),
    .awvalid   (S_AXI_AWVALID),
    .awready   (S_AXI_AWREADY),
    .wdata     (S_AXI_WDATA),
    .wstrb     (S_AXI_WSTRB),
    .wvalid    (S_AXI_WVALID),
    .wready    (S_AXI_WREADY),
    .bresp     (S_AXI_BRESP),
    .bvalid    (S_AXI_BVALID),
    .bready    (S_AXI_BREADY),
    .araddr    (S_AXI_ARADDR),
    .arvalid   (S_AXI_ARVALID),
    .arready   (S_AXI_ARREADY),
    .rdata     (S_AXI_RDATA),
    .rresp     (S_AXI_RRESP),
    .rvalid    (S_AXI_RVALID),
    .rready    (S_AXI_RREADY),
    .wr_o      (wr),
    .wr_addr_o (wr_addr),
    .wr_data_o (wr_data),
    .wr_strb_o (wr_strb),
    .wr_err_i  (wr_err),
    .rd_o      (rd),
    .rd_addr_o (rd_addr),
    .rd_data_i (rd_data),
    .rd_err_i  (rd_err)
  );

  // counter halts only in full halt
  assign pre_en = (pwr_r != rtb_pkg::PWR_HALT);

  rtb_prescaler #(
    .D0 (`RTB_CNT_W'(DIV_00)),
    .D1 (`RTB_CNT_W'(DIV_01)),
    .D2 (`RTB_CNT_W'(DIV_10)),
    .D3 (`RTB_CNT_W'(DIV_11))
  ) u_pre (
    .clk       (SYS_CLK),
    .srst      (SRST),
    .en        (pre_en),
    .sel_i     (tb_r),
    .tick_o    (tick),
    .cnt_o     (cnt),
    .act_sel_o (act_sel)
  );

  // ****************************************
  // register access decode
  // ****************************************
  // control/status register access is frozen while the cpu sleeps in halt
  assign frozen = (pwr_r == rtb_pkg::PWR_AHALT) || (pwr_r == rtb_pkg::PWR_HALT);
  assign tbc_wr = wr && (wr_addr & 8'hfc) == A_TBC && wr_strb[0] && !frozen;
  assign tbc_rd = rd && (rd_addr & 8'hfc) == A_TBC && !frozen;

  // write address check
  always_comb begin
    if ((wr_addr & 8'hfc) == A_SIS) begin
      wr_err = 1'b0;
    end else if ((wr_addr & 8'hfc) == A_TBC) begin
      wr_err = 1'b0;
    end else if ((wr_addr & 8'hfc) == A_IST) begin
      wr_err = 1'b0;
    end else if ((wr_addr & 8'hfc) == A_IMK) begin
      wr_err = 1'b0;
    end else begin
      wr_err = 1'b1;
    end
  end

  // read data mux, upper bits zero
  always_comb begin
    rd_data = 32'h0;
    rd_err  = 1'b0;
    if ((rd_addr & 8'hfc) == A_SIS) begin
      rd_data = 32'h0;
    end else if ((rd_addr & 8'hfc) == A_TBC) begin
      rd_data[`RTB_TB_MSB:`RTB_TB_LSB] = tb_r;
      rd_data[`RTB_OIE_BIT]            = oie_r;
      rd_data[`RTB_OIF_BIT]            = oif_r;
    end else if ((rd_addr & 8'hfc) == A_IST) begin
      rd_data[`RTB_EV_W-1:0] = ist_r;
    end else if ((rd_addr & 8'hfc) == A_IMK) begin
      rd_data[`RTB_EV_W-1:0] = imk_r;
    end else begin
      rd_err = 1'b1;
    end
  end

  // ****************************************
  // control/status register
  // ****************************************
  // period code and enable, written by software
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      tb_r  <= 2'(`RTB_TBC_RST >> `RTB_TB_LSB);
      oie_r <= 1'(`RTB_TBC_RST >> `RTB_OIE_BIT);
    end else if (tbc_wr) begin
      tb_r  <= wr_data[`RTB_TB_MSB:`RTB_TB_LSB];
      oie_r <= wr_data[`RTB_OIE_BIT];
    end
  end

  // overflow flag: set by tick, cleared by read, set wins
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      oif_r <= 1'b0;
    end else if (tick) begin
      oif_r <= 1'b1;
    end else if (tbc_rd) begin
      oif_r <= 1'b0;
    end
  end

  // tick request only while enabled
  assign TICK_IRQ = oie_r && oif_r;

  // ****************************************
  // power state tracking
  // ****************************************
  // next power state from cpu requests and wake sources
  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      rtb_pkg::PWR_RUN: begin
        if (CPU_HALT_REQ) begin
          pwr_nxt = oie_r ? rtb_pkg::PWR_AHALT : rtb_pkg::PWR_HALT;
        end else if (CPU_WAIT_REQ) begin
          pwr_nxt = rtb_pkg::PWR_WAIT;
        end
      end
      rtb_pkg::PWR_WAIT: begin
        if (TICK_IRQ || EXT_WAKE) begin
          pwr_nxt = rtb_pkg::PWR_RUN;
        end
      end
      rtb_pkg::PWR_AHALT: begin
        if (TICK_IRQ || EXT_WAKE) begin
          pwr_nxt = rtb_pkg::PWR_RUN;
        end
      end
      rtb_pkg::PWR_HALT: begin
        if (EXT_WAKE) begin
          pwr_nxt = rtb_pkg::PWR_RUN;
        end
      end
      default: pwr_nxt = rtb_pkg::PWR_RUN;
    endcase
  end

  // power state register
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      pwr_r <= rtb_pkg::PWR_RUN;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  assign PWR_STATE = pwr_r;

  // ****************************************
  // event interrupt
  // ****************************************
  assign wake_ev = (pwr_r != rtb_pkg::PWR_RUN) && (pwr_nxt == rtb_pkg::PWR_RUN) && TICK_IRQ;
  assign ev      = {wake_ev, tick};

  // sticky status bits, write one to clear, set wins
  generate
    for (genvar i = 0; i < `RTB_EV_W; i++) begin : g_ev
      always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
          ist_r[i] <= 1'b0;
        end else if (ev[i]) begin
          ist_r[i] <= 1'b1;
        end else if (wr && (wr_addr & 8'hfc) == A_IST && wr_strb[0] && wr_data[i]) begin
          ist_r[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // mask register
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      imk_r <= '0;
    end else if (wr && (wr_addr & 8'hfc) == A_IMK && wr_strb[0]) begin
      imk_r <= wr_data[`RTB_EV_W-1:0];
    end
  end

  assign IRQ = |(ist_r & imk_r);

  // ****************************************
  // checks
  // ****************************************
  logic [`RTB_CNT_W-1:0] gap_r;
  logic [`RTB_CNT_W-1:0] div_act;

  // cycles of advance since last period end
  always_ff @(posedge SYS_CLK) begin
    if (SRST || tick) begin
      gap_r <= 18'h0;
    end else if (pre_en) begin
      gap_r <= gap_r + 18'h1;
    end
  end

  // ratio in force for the running period
  always_comb begin
    case (act_sel)
      2'h0:    div_act = `RTB_CNT_W'(DIV_00);
      2'h1:    div_act = `RTB_CNT_W'(DIV_01);
      2'h2:    div_act = `RTB_CNT_W'(DIV_10);
      default: div_act = `RTB_CNT_W'(DIV_11);
    endcase
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);

  sequence s_halt_enabled;
    pwr_r == rtb_pkg::PWR_RUN && CPU_HALT_REQ && oie_r;
  endsequence
  sequence s_in_ahalt;
    pwr_r == rtb_pkg::PWR_AHALT && !tick;
  endsequence

  a_tick_period: assert property (tick |-> gap_r == div_act - 18'h1)
    else $error("period length differs from ratio");
  a_sel_hold: assert property (!tick |=> $stable(act_sel))
    else $error("ratio changed inside a period");
  a_sel_load: assert property (tick |=> act_sel == $past(tb_r))
    else $error("new ratio not taken at period end");
  a_restart_zero: assert property (tick |=> cnt == 18'h0)
    else $error("prescaler did not restart");
  a_flag_set: assert property (tick |=> oif_r)
    else $error("overflow flag not set");
  a_flag_read: assert property (tbc_rd && !tick |=> !oif_r)
    else $error("read did not clear flag");
  a_irq_gate: assert property (!oie_r |-> !TICK_IRQ)
    else $error("request without enable");
  a_ahalt_enter: assert property (s_halt_enabled |=> pwr_r == rtb_pkg::PWR_AHALT)
    else $error("enabled halt not active halt");
  a_ahalt_count: assert property (s_in_ahalt |=> cnt == $past(cnt) + 18'h1)
    else $error("counter stopped in active halt");
  a_halt_freeze: assert property (pwr_r == rtb_pkg::PWR_HALT |=> $stable(cnt))
    else $error("counter moved in full halt");
  a_halt_nowake: assert property (pwr_r == rtb_pkg::PWR_HALT && !EXT_WAKE |=> pwr_r == rtb_pkg::PWR_HALT)
    else $error("tick woke full halt");
  a_wait_exit: assert property (pwr_r == rtb_pkg::PWR_WAIT && TICK_IRQ |=> pwr_r == rtb_pkg::PWR_RUN)
    else $error("tick did not end wait");
  a_reg_frozen: assert property (frozen |=> $stable(tb_r) && $stable(oie_r))
    else $error("register changed while frozen");
  a_enable_write: assert property (tbc_wr |=> oie_r == $past(wr_data[`RTB_OIE_BIT]))
    else $error("enable bit not written");
endmodule : rtb_timebase
`default_nettype wire

//--- rtl/rtb_map.svh
/*
  Constants of the time-base block: register indices, field positions,
  reset values and prescaler ratios.
  Assumes inclusion by bare name; holds definitions only.
*/
`ifndef RTB_MAP_SVH
`define RTB_MAP_SVH
// ****************************************
// register indices, byte address is four times
// ****************************************
`define RTB_IDX_SIS   8'h25
`define RTB_IDX_TBC   8'h26
`define RTB_IDX_IST   8'h30
`define RTB_IDX_IMK   8'h31
// ****************************************
// fields and reset values
// ****************************************
`define RTB_OIF_BIT   0
`define RTB_OIE_BIT   1
`define RTB_TB_LSB    2
`define RTB_TB_MSB    3
`define RTB_TBC_RST   8'h00
`define RTB_EV_OVF    0
`define RTB_EV_WAKE   1
`define RTB_EV_W      2
// ****************************************
// prescaler ratios and bus answers
// ****************************************
`define RTB_CNT_W     18
`define RTB_DIV0      16000
`define RTB_DIV1      32000
`define RTB_DIV2      80000
`define RTB_DIV3      200000
`define RTB_RESP_OK   2'h0
`define RTB_RESP_ERR  2'h2
`endif

//--- rtl/rtb_pkg.sv
/*
  Types of the time-base block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rtb_pkg;
  // cpu power state, one-hot
  typedef enum logic [3:0] {
    PWR_RUN   = 4'h1,
    PWR_WAIT  = 4'h2,
    PWR_AHALT = 4'h4,
    PWR_HALT  = 4'h8
  } rtb_pwr_t;
endpackage : rtb_pkg

//--- rtl/rtb_prescaler.sv
/*
  Prescaler of the time base: divides the clock by one of four ratios.
  Assumes en is high in every cycle the counter may advance.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rtb_map.svh"
module rtb_prescaler #(
  parameter logic [`RTB_CNT_W-1:0] D0 = 18'h0,
  parameter logic [`RTB_CNT_W-1:0] D1 = 18'h0,
  parameter logic [`RTB_CNT_W-1:0] D2 = 18'h0,
  parameter logic [`RTB_CNT_W-1:0] D3 = 18'h0
) (
  input  wire logic                  clk,       // system clock
  input  wire logic                  srst,      // sync reset
  input  wire logic                  en,        // advance enable
  input  wire logic [1:0]            sel_i,     // requested ratio
  output logic                       tick_o,    // period end pulse
  output logic [`RTB_CNT_W-1:0]      cnt_o,     // current count
  output logic [1:0]                 act_sel_o  // ratio in use
);
  logic [`RTB_CNT_W-1:0] cnt_r;
  logic [1:0]            act_r;
  logic [`RTB_CNT_W-1:0] term;

  // terminal count of the ratio in use
  always_comb begin
    case (act_r)
      2'h0:    term = D0 - 18'h1;
      2'h1:    term = D1 - 18'h1;
      2'h2:    term = D2 - 18'h1;
      default: term = D3 - 18'h1;
    endcase
  end

  assign tick_o    = en && (cnt_r == term);
  assign cnt_o     = cnt_r;
  assign act_sel_o = act_r;

  // count, restart and pick up a new ratio at period end
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r <= 18'h0;
      act_r <= 2'h0;
    end else if (tick_o) begin
      cnt_r <= 18'h0;
      act_r <= sel_i;
    end else if (en) begin
      cnt_r <= cnt_r + 18'h1;
    end
  end
endmodule : rtb_prescaler
`default_nettype wire

//--- rtl/rtb_axil.sv
/*
  AXI4-Lite slave front end: turns bus transfers into one-cycle
  register strobes. Assumes the register file answers in the same cycle.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rtb_map.svh"
module rtb_axil (
  input  wire logic        clk,       // system clock
  input  wire logic        srst,      // sync reset
  input  wire logic [7:0]  awaddr,    // write address
  input  wire logic        awvalid,   // write address valid
  output logic             awready,   // write address ready
  input  wire logic [31:0] wdata,     // write data
  input  wire logic [3:0]  wstrb,     // byte enables
  input  wire logic        wvalid,    // write data valid
  output logic             wready,    // write data ready
  output logic [1:0]       bresp,     // write response
  output logic             bvalid,    // write response valid
  input  wire logic        bready,    // write response ready
  input  wire logic [7:0]  araddr,    // read address
  input  wire logic        arvalid,   // read address valid
  output logic             arready,   // read address ready
  output logic [31:0]      rdata,     // read data
  output logic [1:0]       rresp,     // read response
  output logic             rvalid,    // read data valid
  input  wire logic        rready,    // read data ready
  output logic             wr_o,      // register write strobe
  output logic [7:0]       wr_addr_o, // write address held
  output logic [31:0]      wr_data_o, // write data held
  output logic [3:0]       wr_strb_o, // byte enables held
  input  wire logic        wr_err_i,  // write address unmapped
  output logic             rd_o,      // register read strobe
  output logic [7:0]       rd_addr_o, // read address held
  input  wire logic [31:0] rd_data_i, // read data of register
  input  wire logic        rd_err_i   // read address unmapped
);
  logic aw_have_r;
  logic w_have_r;
  logic rd_pend_r;

  assign awready = !aw_have_r && !bvalid;
  assign wready  = !w_have_r && !bvalid;
  assign arready = !rd_pend_r && !rvalid;
  assign wr_o    = aw_have_r && w_have_r;
  assign rd_o    = rd_pend_r;

  // write side: capture address and data in either order
  always_ff @(posedge clk) begin
    if (srst) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      wr_addr_o <= 8'h0;
      wr_data_o <= 32'h0;
      wr_strb_o <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= `RTB_RESP_OK;
    end else begin
      if (awvalid && awready) begin
        aw_have_r <= 1'b1;
        wr_addr_o <= awaddr;
      end
      if (wvalid && wready) begin
        w_have_r  <= 1'b1;
        wr_data_o <= wdata;
        wr_strb_o <= wstrb;
      end
      if (wr_o) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= wr_err_i ? `RTB_RESP_ERR : `RTB_RESP_OK;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // read side: address, one strobe cycle, then data
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_pend_r <= 1'b0;
      rd_addr_o <= 8'h0;
      rvalid    <= 1'b0;
      rdata     <= 32'h0;
      rresp     <= `RTB_RESP_OK;
    end else if (arvalid && arready) begin
      rd_pend_r <= 1'b1;
      rd_addr_o <= araddr;
    end else if (rd_pend_r) begin
      rd_pend_r <= 1'b0;
      rvalid    <= 1'b1;
      rdata     <= rd_data_i;
      rresp     <= rd_err_i ? `RTB_RESP_ERR : `RTB_RESP_OK;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule : rtb_axil
`default_nettype wire

//--- tb/rtb_cpu_model.sv
/*
  cpu stand-in: turns bench requests into instruction and wake pulses.
  assumes requests are one cycle long and change after a rising edge.
*/
`timescale 1ns/100ps
`default_nettype none
module rtb_cpu_model (
  input  wire logic       clk,      // system clock
  input  wire logic       srst,     // sync reset
  input  wire logic [1:0] op,       // 1 wait, 2 halt, 3 wake
  input  wire logic [3:0] pwr,      // power state seen
  output logic            wait_req, // wait pulse
  output logic            halt_req, // halt pulse
  output logic            wake      // other wake source
);
  // instructions only issue while running; wake from any state
  always_ff @(posedge clk) begin
    wait_req <= !srst && op == 2'h1 && pwr == rtb_pkg::PWR_RUN;
    halt_req <= !srst && op == 2'h2 && pwr == rtb_pkg::PWR_RUN;
    wake     <= !srst && op == 2'h3;
  end
endmodule : rtb_cpu_model
`default_nettype wire

//--- tb/clock_controller_rtc_timebase_bench.sv
/*
  bench of the time base: bus master, cpu stand-in, queued checks.
  assumes small prescaler ratios set through the top parameters.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rtb_map.svh"
module clock_controller_rtc_timebase_bench;
  // ****************************************
  // signals
  // ****************************************
  localparam int D [4] = '{20, 30, 50, 70};
  localparam logic [7:0] A_TBC = `RTB_IDX_TBC << 2;
  localparam logic [7:0] A_SIS = `RTB_IDX_SIS << 2;
  localparam logic [7:0] A_IST = `RTB_IDX_IST << 2;
  localparam logic [7:0] A_IMK = `RTB_IDX_IMK << 2;
  localparam logic [1:0] OK = `RTB_RESP_OK;
  localparam logic [1:0] ER = `RTB_RESP_ERR;
  logic        clk = 0, srst = 1;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 32'h0, rdata, seed = 32'hf0369018;
  logic [1:0]  op = 2'h0, bresp, rresp;
  logic [3:0]  pwr;
  logic        awready, wready, arready, bvalid, rvalid, tick, irq, wreq, hreq, wake;
  logic [65:0] exp_r [$];
  logic [1:0]  exp_b [$];
  int          exp_gap [$];
  int          errors = 0, n_tests = 0, cyc = 0, last_rise = 0;
  logic        tick_d = 0;
  always #12.5 clk = ~clk;
  rtb_timebase #(.DIV_00(D[0]), .DIV_01(D[1]), .DIV_10(D[2]), .DIV_11(D[3])) i_dut (
    .SYS_CLK(clk), .SRST(srst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .CPU_WAIT_REQ(wreq), .CPU_HALT_REQ(hreq), .EXT_WAKE(wake), .PWR_STATE(pwr),
    .TICK_IRQ(tick), .IRQ(irq));
  rtb_cpu_model i_cpu (.clk(clk), .srst(srst), .op(op), .pwr(pwr), .wait_req(wreq),
    .halt_req(hreq), .wake(wake));
  // ****************************************
  // tasks
  // ****************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : cmp
  task automatic summarize();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // whole-word writes only, never read-modify-write
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r);
    logic aw, w, ta, tw;
    aw = 1;
    w = 1;
    exp_b.push_back(r);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (aw || w) begin
      @(negedge clk); ta = awready; tw = wready;
      @(posedge clk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      aw = aw && !ta;
      w = w && !tw;
    end
    @(negedge clk); while (!bvalid) @(negedge clk);
    @(posedge clk);
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m, logic [1:0] r);
    logic t;
    t = 0;
    exp_r.push_back({e, m, r});
    araddr <= a; arvalid <= 1; rready <= 1;
    while (!t) begin
      @(negedge clk); t = arready;
      @(posedge clk);
    end
    arvalid <= 0;
    @(negedge clk); while (!rvalid) @(negedge clk);
    @(posedge clk);
  endtask : rd
  task automatic pw(logic [3:0] e, int n);
    repeat (n) begin
      @(negedge clk);
      if (pwr === e) break;
    end
    cmp("pwr", 32'(e), 32'(pwr));
    @(posedge clk);
  endtask : pw
  task automatic at_neg(string nm, logic e);
    @(negedge clk); cmp(nm, 32'(e), nm == "irq" ? 32'(irq) : 32'(tick));
    @(posedge clk);
  endtask : at_neg
  task automatic cpu(logic [1:0] o);
    op <= o; @(posedge clk); op <= 2'h0;
  endtask : cpu
  task automatic rise();
    @(negedge clk); while (!tick) @(negedge clk);
    @(posedge clk);
  endtask : rise
  // ****************************************
  // result watcher and timeout
  // ****************************************
  always @(negedge clk) begin
    logic [65:0] x;
    if (bvalid && bready) cmp("bresp", 32'(exp_b.pop_front()), 32'(bresp));
    if (rvalid && rready) begin
      x = exp_r.pop_front();
      cmp("rdata", x[65:34], rdata & x[33:2]);
      cmp("rresp", 32'(x[1:0]), 32'(rresp));
    end
    if (tick && !tick_d) begin
      if (exp_gap.size() > 0) cmp("period", 32'(exp_gap.pop_front()), 32'(cyc - last_rise));
      last_rise = cyc;
    end
    tick_d = tick;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      errors++;
      summarize();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [31:0] v;
    repeat (20) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    rd(A_TBC, 32'h0, '1, OK);
    rd(A_SIS, 32'h0, '1, OK);
    wr(8'h10, rnd(), ER);
    rd(8'h10, 32'h0, '1, ER);
    $display("test reset done");
    v = rnd();
    wr(A_TBC, {v[31:4], 3'h1, v[0]}, OK);
    rise();
    rd(A_TBC, 32'h3, 32'hff, OK);
    for (int c = 1; c <= 4; c++) begin
      v = rnd();
      wr(A_TBC, {v[31:4], 2'(c), 1'b1, v[0]}, OK);
      exp_gap.push_back(D[(c - 1) % 4]);
      exp_gap.push_back(D[c % 4]);
      repeat (2) begin
        rise();
        rd(A_TBC, {28'h0, 2'(c), 2'h3}, 32'hff, OK);
      end
    end
    $display("test period done");
    cpu(2'h1);
    pw(rtb_pkg::PWR_WAIT, 4);
    pw(rtb_pkg::PWR_RUN, 3 * D[0]);
    rd(A_IST, 32'h2, 32'h2, OK);
    rd(A_TBC, 32'h3, 32'hff, OK);
    $display("test wait done");
    cpu(2'h2);
    pw(rtb_pkg::PWR_AHALT, 4);
    wr(A_TBC, 32'hc, OK);
    pw(rtb_pkg::PWR_RUN, 3 * D[0]);
    rd(A_TBC, 32'h3, 32'hff, OK);
    $display("test active halt done");
    wr(A_TBC, 32'h0, OK);
    cpu(2'h2);
    pw(rtb_pkg::PWR_HALT, 4);
    repeat (3 * D[0]) @(posedge clk);
    pw(rtb_pkg::PWR_HALT, 1);
    cpu(2'h3);
    pw(rtb_pkg::PWR_RUN, 4);
    $display("test halt done");
    repeat (2 * D[0]) @(posedge clk);
    at_neg("tick", 1'b0);
    rd(A_TBC, 32'h1, 32'h1, OK);
    wr(A_IMK, 32'h0, OK);
    at_neg("irq", 1'b0);
    wr(A_IMK, 32'h1, OK);
    at_neg("irq", 1'b1);
    wr(A_IMK, 32'h2, OK);
    wr(A_IST, 32'h3, OK);
    at_neg("irq", 1'b0);
    rd(A_IST, 32'h0, 32'h2, OK);
    $display("test irq done");
    summarize();
  end
endmodule : clock_controller_rtc_timebase_bench
`default_nettype wire
